// ---- rtl/pem_defs.svh ----
// constants for the phy event interrupt mask block
// assumes inclusion by bare name from the package and design files
// Contract
// - with the checksum gate bit (bit 7) clear, a receive ends as finished on its last octet whatever the checksum says.
// - with the checksum gate bit set, a receive finishes only if checksum good is 1 at frame end, else preamble search restarts.
// - synth lock loss always sets its flag and may drive the interrupt only while mask bit 6 is 0.
// - a frame filter reject always sets its flag and drives the interrupt only while mask bit 5 is 0.
// - a byte count strobed in equal to the level threshold sets the level flag and interrupts only while mask bit 4 is 0.
// - a finished channel check sets its flag and interrupts only while mask bit 3 is 0.
// - a finished receive sets its flag and interrupts only while mask bit 2 is 0.
// - a finished transmit sets its flag and interrupts only while mask bit 1 is 0.
// - a finished autosequence sets its flag and interrupts only while mask bit 0 is 0.
// - the mask register sits at offset 4h, is 8-bit read/write and resets to all ones.
// - the global interrupt mask, when set, blocks every source from the interrupt line.
`ifndef PEM_DEFS_SVH
`define PEM_DEFS_SVH

// register byte offsets
`define PEM_STATUS_OFF 8'h00
`define PEM_MASK_OFF 8'h04
`define PEM_GLOBAL_OFF 8'h08
`define PEM_LEVEL_OFF 8'h0c

// reset values
`define PEM_MASK_RST 8'hff
`define PEM_FLAGS_RST 7'h00
`define PEM_LEVEL_RST 8'h00

// field positions
`define PEM_CHK_BIT 7
`define PEM_LOCK_BIT 6
`define PEM_FILT_BIT 5
`define PEM_LEVEL_BIT 4
`define PEM_CCA_BIT 3
`define PEM_RX_BIT 2
`define PEM_TX_BIT 1
`define PEM_SEQ_BIT 0
`define PEM_GLOBAL_BIT 7

`endif

// ---- rtl/pem_pkg.sv ----
// types shared by the phy event interrupt mask block
// assumes the defines header is on the include path
package pem_pkg;
  `include "pem_defs.svh"

  // axi4-lite response codes
  typedef enum logic [1:0] {
    PEM_OKAY = 2'b00,
    PEM_SLVERR = 2'b10
  } pem_resp_t;

  // receive end decision states
  typedef enum logic [0:0] {
    PEM_RX_WAIT = 1'b0,
    PEM_RX_JUDGE = 1'b1
  } pem_rx_state_t;
endpackage

// ---- rtl/pem_rx_end.sv ----
// receive end decision for the sequence manager
// assumes last octet pulse and checksum level come from the same clock
`timescale 1ns/100ps
module pem_rx_end (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // receive path
  input wire logic rx_last_octet,
  input wire logic checksum_good,
  input wire logic checksum_gate_enable,
  // decisions
  output logic rx_complete,
  output logic rx_restart_search
);
  import pem_pkg::*;

  logic rx_complete_reg;
  logic rx_complete_next;
  logic restart_reg;
  logic restart_next;
  wire logic chk_ok;

  // checksum only counts when the gate is on
  assign chk_ok = ~checksum_gate_enable | checksum_good;
  assign rx_complete_next = rx_last_octet & chk_ok;
  assign restart_next = rx_last_octet & ~chk_ok;

  // one-cycle decision pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_complete_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      rx_complete_reg <= rx_complete_next;
      restart_reg <= restart_next;
    end
  end

  assign rx_complete = rx_complete_reg;
  assign rx_restart_search = restart_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_gate_off_done;
    (rx_last_octet && !checksum_gate_enable) |=> rx_complete_reg;
  endproperty
  a_gate_off_done: assert property (p_gate_off_done)
    else $error("ungated receive did not finish");

  sequence s_bad_end;
    rx_last_octet && checksum_gate_enable && !checksum_good;
  endsequence
  property p_gate_on_bad;
    s_bad_end |=> (restart_reg && !rx_complete_reg);
  endproperty
  a_gate_on_bad: assert property (p_gate_on_bad)
    else $error("bad checksum did not restart search");
endmodule

// ---- rtl/pem_top.sv ----
// phy event interrupt mask block with axi4-lite register access
// assumes radio event inputs are one-cycle pulses on aclk
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`include "pem_defs.svh"
module pem_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output pem_pkg::pem_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output pem_pkg::pem_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // radio events
  input wire logic synth_lock_loss,
  input wire logic frame_filter_reject,
  input wire logic rx_byte_strobe,
  input wire logic [7:0] rx_byte_count,
  input wire logic channel_check_done,
  input wire logic rx_last_octet,
  input wire logic checksum_good,
  input wire logic transmit_done,
  input wire logic sequence_done,
  // to sequence manager and host
  output logic rx_complete,
  output logic rx_restart_search,
  output logic irq_n
);
  import pem_pkg::*;

  // address match, used by both read and write decode
  function automatic logic pem_hit(input logic [7:0] addr,
                                   input logic [7:0] off);
    pem_hit = (addr[7:2] == off[7:2]);
  endfunction

  // registers
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [6:0] flags_reg;
  logic [6:0] flags_next;
  logic global_reg;
  logic global_next;
  logic [7:0] level_reg;
  logic [7:0] level_next;
  logic irq_n_reg;
  logic irq_n_next;

  // write channel state
  logic [7:0] aw_addr_reg;
  logic aw_full_reg;
  logic aw_full_next;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic w_full_next;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic bvalid_next;
  pem_resp_t bresp_reg;
  pem_resp_t bresp_next;

  // read channel state
  logic arready_reg;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  pem_resp_t rresp_reg;
  pem_resp_t rresp_next;

  wire logic rx_done;

  // receive end decision
  pem_rx_end u_rx_end (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx_last_octet(rx_last_octet),
    .checksum_good(checksum_good),
    .checksum_gate_enable(mask_reg[`PEM_CHK_BIT]),
    .rx_complete(rx_done),
    .rx_restart_search(rx_restart_search)
  );
  assign rx_complete = rx_done;

  // write handshake decode
  wire logic aw_take;
  wire logic w_take;
  wire logic do_write;
  wire logic wr_lane0;
  wire logic wr_status;
  wire logic wr_mask;
  wire logic wr_global;
  wire logic wr_level;
  wire logic wr_mapped;
  assign aw_take = awvalid & awready_reg;
  assign w_take = wvalid & wready_reg;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_lane0 = do_write & w_strb_reg[0];
  assign wr_status = pem_hit(aw_addr_reg, `PEM_STATUS_OFF);
  assign wr_mask = pem_hit(aw_addr_reg, `PEM_MASK_OFF);
  assign wr_global = pem_hit(aw_addr_reg, `PEM_GLOBAL_OFF);
  assign wr_level = pem_hit(aw_addr_reg, `PEM_LEVEL_OFF);
  assign wr_mapped = wr_status | wr_mask | wr_global | wr_level;

  // write channel sequencing: address and data in either order
  assign aw_full_next = do_write ? 1'b0 : (aw_full_reg | aw_take);
  assign w_full_next = do_write ? 1'b0 : (w_full_reg | w_take);
  assign bvalid_next = do_write | (bvalid_reg & ~bready);
  assign bresp_next = do_write ? (wr_mapped ? PEM_OKAY : PEM_SLVERR)
                               : bresp_reg;

  // events; the level match fires when a new byte count meets threshold
  wire logic level_hit;
  wire logic [6:0] set_vec;
  wire logic [6:0] clr_vec;
  assign level_hit = rx_byte_strobe & (rx_byte_count == level_reg);
  assign set_vec = {synth_lock_loss, frame_filter_reject, level_hit,
                    channel_check_done, rx_done, transmit_done,
                    sequence_done};
  assign clr_vec = (wr_lane0 & wr_status) ? w_data_reg[6:0] : 7'h00;

  // flags set regardless of mask, set wins over a write-one clear
  assign flags_next = (flags_reg & ~clr_vec) | set_vec;
  assign mask_next = (wr_lane0 & wr_mask) ? w_data_reg[7:0]
                                          : mask_reg;
  assign global_next = (wr_lane0 & wr_global)
                       ? w_data_reg[`PEM_GLOBAL_BIT] : global_reg;
  assign level_next = (wr_lane0 & wr_level) ? w_data_reg[7:0] : level_reg;

  // interrupt: any unmasked flag, unless globally blocked
  wire logic pending;
  assign pending = (|(flags_reg & ~mask_reg[6:0])) & ~global_reg;
  assign irq_n_next = ~pending;

  // read decode
  wire logic ar_take;
  wire logic rd_status;
  wire logic rd_mask;
  wire logic rd_global;
  wire logic rd_level;
  assign ar_take = arvalid & arready_reg;
  assign rd_status = pem_hit(araddr, `PEM_STATUS_OFF);
  assign rd_mask = pem_hit(araddr, `PEM_MASK_OFF);
  assign rd_global = pem_hit(araddr, `PEM_GLOBAL_OFF);
  assign rd_level = pem_hit(araddr, `PEM_LEVEL_OFF);
  assign rvalid_next = ar_take | (rvalid_reg & ~rready);

  // read data selection, unused bits read as zero
  always_comb begin
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      rresp_next = PEM_OKAY;
      if (rd_status) begin
        rdata_next = {25'h0000000, flags_reg};
      end else if (rd_mask) begin
        rdata_next = {24'h000000, mask_reg};
      end else if (rd_global) begin
        rdata_next = {24'h000000, global_reg, 7'h00};
      end else if (rd_level) begin
        rdata_next = {24'h000000, level_reg};
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = PEM_SLVERR;
      end
    end
  end

  // control and status registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= `PEM_MASK_RST;
      flags_reg <= `PEM_FLAGS_RST;
      global_reg <= 1'b0;
      level_reg <= `PEM_LEVEL_RST;
      irq_n_reg <= 1'b1;
    end else begin
      mask_reg <= mask_next;
      flags_reg <= flags_next;
      global_reg <= global_next;
      level_reg <= level_next;
      irq_n_reg <= irq_n_next;
    end
  end

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= PEM_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= ~aw_full_next;
      wready_reg <= ~w_full_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // captured write payload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (aw_take) aw_addr_reg <= awaddr;
      if (w_take) w_data_reg <= wdata;
      if (w_take) w_strb_reg <= wstrb;
    end
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= PEM_OKAY;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // outputs straight from flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq_n = irq_n_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_lock_flag;
    synth_lock_loss |=> flags_reg[`PEM_LOCK_BIT];
  endproperty
  a_lock_flag: assert property (p_lock_flag)
    else $error("lock loss flag not set");

  property p_filt_flag;
    frame_filter_reject |=> flags_reg[`PEM_FILT_BIT];
  endproperty
  a_filt_flag: assert property (p_filt_flag)
    else $error("filter reject flag not set");

  property p_level_flag;
    (rx_byte_strobe && rx_byte_count == level_reg)
      |=> flags_reg[`PEM_LEVEL_BIT];
  endproperty
  a_level_flag: assert property (p_level_flag)
    else $error("level flag not set on match");

  property p_cca_flag;
    channel_check_done |=> flags_reg[`PEM_CCA_BIT];
  endproperty
  a_cca_flag: assert property (p_cca_flag)
    else $error("channel check flag not set");

  property p_rx_flag;
    rx_last_octet && (!mask_reg[`PEM_CHK_BIT] || checksum_good)
      |=> ##1 flags_reg[`PEM_RX_BIT];
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("receive flag not set");

  property p_tx_flag;
    transmit_done |=> flags_reg[`PEM_TX_BIT];
  endproperty
  a_tx_flag: assert property (p_tx_flag)
    else $error("transmit flag not set");

  property p_seq_flag;
    sequence_done |=> flags_reg[`PEM_SEQ_BIT];
  endproperty
  a_seq_flag: assert property (p_seq_flag)
    else $error("sequence flag not set");

  property p_mask_read;
    (ar_take && rd_mask) |=> (rvalid_reg && rdata_reg[7:0] == $past(mask_reg));
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read data wrong");

  property p_global_block;
    global_reg |=> irq_n_reg;
  endproperty
  a_global_block: assert property (p_global_block)
    else $error("interrupt driven under global mask");

  property p_irq_level;
    (|(flags_reg & ~mask_reg[6:0]) && !global_reg) |=> !irq_n_reg;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt not driven for unmasked flag");

  property p_masked_quiet;
    ((flags_reg & ~mask_reg[6:0]) == 7'h00) |=> irq_n_reg;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("interrupt driven with all flags masked");
endmodule

// ---- bench/pem_host.sv ----
// host side model: counts interrupt requests seen on the line
// assumes irq_n is an active-low level on aclk
`timescale 1ns/100ps
module pem_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // interrupt line and tally
  input wire logic irq_n,
  output logic [7:0] irq_count
);
  logic irq_last;
  // count each new assertion of the line
  always_ff @(posedge aclk) begin
    irq_last <= irq_n;
    if (!aresetn) irq_count <= 8'h00;
    else if (irq_last && !irq_n) irq_count <= irq_count + 8'h01;
  end
endmodule

// ---- bench/test_phy_event_interrupt_mask.sv ----
// self-checking bench for the phy event interrupt mask block
// assumes the design files and the host model are compiled first
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
  num_errors++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module test_phy_event_interrupt_mask;
  import pem_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, rx_byte_count, irq_count;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  pem_resp_t bresp, rresp, rsp;
  logic synth_lock_loss, frame_filter_reject, rx_byte_strobe;
  logic channel_check_done, rx_last_octet, checksum_good;
  logic transmit_done, sequence_done, rx_complete, rx_restart_search, irq_n;
  int num_errors = 0;
  int n_tests = 0;

  pem_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .synth_lock_loss(synth_lock_loss),
    .frame_filter_reject(frame_filter_reject),
    .rx_byte_strobe(rx_byte_strobe), .rx_byte_count(rx_byte_count),
    .channel_check_done(channel_check_done),
    .rx_last_octet(rx_last_octet), .checksum_good(checksum_good),
    .transmit_done(transmit_done), .sequence_done(sequence_done),
    .rx_complete(rx_complete), .rx_restart_search(rx_restart_search),
    .irq_n(irq_n));
  pem_host i_host (.aclk(aclk), .aresetn(aresetn), .irq_n(irq_n),
    .irq_count(irq_count));

  // 20 mhz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // register write: address and data offered together, each released
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (awvalid || wvalid) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  // register read
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // one-cycle event pulse, then time for flag and line to settle
  task automatic fire(input int i);
    @(posedge aclk);
    case (i)
      6: synth_lock_loss <= 1'b1;
      5: frame_filter_reject <= 1'b1;
      4: rx_byte_strobe <= 1'b1;
      3: channel_check_done <= 1'b1;
      2: rx_last_octet <= 1'b1;
      1: transmit_done <= 1'b1;
      default: sequence_done <= 1'b1;
    endcase
    @(posedge aclk);
    {synth_lock_loss, frame_filter_reject, rx_byte_strobe,
     channel_check_done, rx_last_octet, transmit_done, sequence_done} <= 7'h00;
    repeat (4) @(posedge aclk);
  endtask

  task automatic test_regs();
    rd_reg(8'h04);
    `CHK("mask reset", 32'h0000_00ff, rd)
    rd_reg(8'h08);
    `CHK("global reset", 32'h0, rd)
    wr(8'h04, 32'hffff_ff5a);
    rd_reg(8'h04);
    `CHK("mask readback", 32'h0000_005a, rd)
    wr(8'h04, 32'h0000_0000, 4'he);
    `CHK("lane0 off resp", PEM_OKAY, rsp)
    rd_reg(8'h04);
    `CHK("lane0 off keeps mask", 32'h0000_005a, rd)
    wr(8'h10, 32'h0);
    `CHK("unmapped write", PEM_SLVERR, rsp)
    rd_reg(8'h10);
    `CHK("unmapped read", PEM_SLVERR, rsp)
    wr(8'h04, 32'hff);
  endtask

  // a byte count off the threshold by one sets nothing
  task automatic test_level();
    wr(8'h0c, 32'h2a);
    rx_byte_count <= 8'h2b;
    fire(4);
    rd_reg(8'h00);
    `CHK("level miss", 32'h0, rd)
    rx_byte_count <= 8'h2a;
  endtask

  // every source masked then unmasked
  task automatic test_events();
    for (int i = 0; i < 7; i++) begin
      wr(8'h04, 32'hff);
      fire(i);
      `CHK("irq", 1'b1, irq_n)
      rd_reg(8'h00);
      `CHK("flag", 32'h1 << i, rd)
      wr(8'h00, 32'h7f);
      wr(8'h04, ~(32'h1 << i) & 32'hff);
      fire(i);
      `CHK("irq unmasked", 1'b0, irq_n)
      wr(8'h00, 32'h1 << i);
      repeat (2) @(posedge aclk);
      `CHK("irq cleared", 1'b1, irq_n)
    end
  endtask

  // global mask holds the line off a pending unmasked flag
  task automatic test_global();
    wr(8'h04, 32'h80);
    wr(8'h08, 32'h80);
    fire(1);
    `CHK("irq global", 1'b1, irq_n)
    wr(8'h08, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK("irq released", 1'b0, irq_n)
    wr(8'h00, 32'h7f);
    wr(8'h04, 32'hff);
    repeat (2) @(posedge aclk);
    `CHK("host count", 8'h08, irq_count)
  endtask

  // receive end decision: gate, checksum, complete, restart
  task automatic test_gate();
    logic [3:0] tab [3];
    tab = '{4'b0010, 4'b1001, 4'b1110};
    for (int k = 0; k < 3; k++) begin
      wr(8'h04, {24'h0, tab[k][3], 7'h7f});
      @(posedge aclk);
      rx_last_octet <= 1'b1;
      checksum_good <= tab[k][2];
      @(posedge aclk);
      rx_last_octet <= 1'b0;
      checksum_good <= 1'b1;
      @(posedge aclk);
      `CHK("rx end", tab[k][1:0], {rx_complete, rx_restart_search})
    end
    wr(8'h00, 32'h7f);
  endtask

  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    finish_test();
  end

  // reset, then the scenarios
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {synth_lock_loss, frame_filter_reject, rx_byte_strobe} = 3'h0;
    {channel_check_done, rx_last_octet, transmit_done, sequence_done} = 4'h0;
    checksum_good = 1'b1;
    rx_byte_count = 8'h2a;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_level();
    test_events();
    test_global();
    test_gate();
    finish_test();
  end
endmodule
